//--- bsl_pkg.sv
// Constants, types and register map of the boot strap latch and decoder.
// Assumes one 125 MHz clock and a plain address/strobe register port.
// Contract
// - Qualifying resets sample both straps, held afterwards
// - Boot-select strap pin weakly pulled up
// - Latched straps readable in strap status register
// - Pins released after reset; latches ignore them
// - Boot-select 1 flash; 0 with print 1 download
// - Download boot offers firmware download over UART
// - Two-bit policy gates boot log printing
// - Enable low is reset, at least 50 us
`default_nettype none

package bsl_pkg;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int CE_LOW_MIN_US  = 50;
  localparam int CE_LOW_CYCLES  = (CE_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;

  localparam logic [ADDR_W-1:0] STRAP_STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STRAP_CTRL_OFS   = 8'h04;

  // Strap bit positions inside the latch
  localparam int PRINT_BIT      = 0;
  localparam int BOOT_SEL_BIT   = 1;
  localparam logic [1:0] STRAP_RESET = 2'h3;

  // Status register fields
  localparam int STS_STRAP_LSB  = 0;
  localparam int STS_MODE_LSB   = 2;
  localparam int STS_PRINT_BIT  = 4;
  localparam int STS_VALID_BIT  = 5;
  localparam int STS_UART_BIT   = 6;
  localparam int STS_POLICY_LSB = 7;

  // Control register fields
  localparam int CTRL_PULLUP_DIS_BIT = 0;

  // Boot log print policy values
  localparam logic [1:0] POLICY_ALWAYS    = 2'h0;
  localparam logic [1:0] POLICY_WHEN_LOW  = 2'h1;
  localparam logic [1:0] POLICY_WHEN_HIGH = 2'h2;
  localparam logic [1:0] POLICY_NEVER     = 2'h3;

  typedef enum logic [1:0] {
    BOOT_FLASH,
    BOOT_JOINT_DOWNLOAD,
    BOOT_INVALID
  } bsl_boot_mode_type;

  typedef enum logic {
    ST_STRAP,
    ST_RUN
  } bsl_state_type;

endpackage

`default_nettype wire

//--- bsl_boot_decode.sv
// Decodes latched strap bits and print policy into boot mode and print gate.
// Assumes its inputs come from latches that change only at a strap sample.
`default_nettype none

module bsl_boot_decode (
  input  wire logic [1:0]                 strapBits,
  input  wire logic [1:0]                 printPolicy,
  output var  bsl_pkg::bsl_boot_mode_type bootMode,
  output var  logic                       printEnable,
  output var  logic                       uartDownload
);

  always_comb begin
    if (strapBits[bsl_pkg::BOOT_SEL_BIT]) begin
      bootMode = bsl_pkg::BOOT_FLASH;
    end else if (strapBits[bsl_pkg::PRINT_BIT]) begin
      bootMode = bsl_pkg::BOOT_JOINT_DOWNLOAD;
    end else begin
      bootMode = bsl_pkg::BOOT_INVALID;
    end
    uartDownload = (bootMode == bsl_pkg::BOOT_JOINT_DOWNLOAD);
  end

  always_comb begin
    unique case (printPolicy)
      bsl_pkg::POLICY_ALWAYS:    printEnable = 1'b1;
      bsl_pkg::POLICY_WHEN_LOW:  printEnable = ~strapBits[bsl_pkg::PRINT_BIT];
      bsl_pkg::POLICY_WHEN_HIGH: printEnable = strapBits[bsl_pkg::PRINT_BIT];
      bsl_pkg::POLICY_NEVER:     printEnable = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

//--- bsl_strap_latch.sv
// Strap latch: samples the two strap pins on qualifying resets, holds them,
// decodes boot mode and print gate, and exposes them over a register port.
// Assumes pin levels and reset causes are synchronous to clk_sys.
`default_nettype none

module bsl_strap_latch #(
  parameter int CE_LOW_CYCLES = bsl_pkg::CE_LOW_CYCLES,
  parameter int ADDR_W        = bsl_pkg::ADDR_W,
  parameter int DATA_W        = bsl_pkg::DATA_W
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic                       chipEnable,
  input  wire logic                       watchdogReset,
  input  wire logic                       brownoutReset,
  input  wire logic                       printStrapPin,
  input  wire logic                       bootSelectStrapPin,
  input  wire logic [1:0]                 bootLogPrintPolicy,
  output var  logic                       bootSelectPullUpEn,
  output var  logic                       strapPinsReleased,
  output var  logic                       chipActive,
  output var  bsl_pkg::bsl_boot_mode_type bootMode,
  output var  logic                       printEnable,
  output var  logic                       uartDownloadEn,
  input  wire logic [ADDR_W-1:0]          regAddr,
  input  wire logic [DATA_W-1:0]          regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output var  logic [DATA_W-1:0]          regRdData
);

  localparam int CNT_W = $clog2(CE_LOW_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(CE_LOW_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CE_LOW_CYCLES - 1);

  bsl_pkg::bsl_state_type     state_reg;
  bsl_pkg::bsl_state_type     state_next;
  logic [CNT_W-1:0]           lowCount_reg;
  logic [1:0]                 strapBits_reg;
  logic [1:0]                 policy_reg;
  logic                       pullUpDis_reg;
  logic                       chipActive_reg;
  bsl_pkg::bsl_boot_mode_type bootMode_reg;
  logic                       printEnable_reg;
  logic                       uartDownload_reg;
  logic [DATA_W-1:0]          regRdData_reg;
  logic [DATA_W-1:0]          statusWord;
  logic [DATA_W-1:0]          ctrlWord;
  logic                       porSet;
  logic                       causeSet;
  logic                       sampleNow;
  bsl_pkg::bsl_boot_mode_type decodedMode;
  logic                       decodedPrint;
  logic                       decodedUart;

  // Enable must stay low for the full minimum time to count as a reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lowCount_reg <= '0;
    end else if (chipEnable) begin
      lowCount_reg <= '0;
    end else if (lowCount_reg != CNT_MAX) begin
      lowCount_reg <= lowCount_reg + CNT_W'(1);
    end
  end

  assign porSet    = !chipEnable && (lowCount_reg == CNT_LAST);
  assign causeSet  = porSet || watchdogReset || brownoutReset;
  assign sampleNow = (state_reg == bsl_pkg::ST_STRAP) && chipEnable && !causeSet;

  // A new cause in the sampling cycle keeps the latch waiting
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bsl_pkg::ST_STRAP: begin
        if (sampleNow) begin
          state_next = bsl_pkg::ST_RUN;
        end
      end
      bsl_pkg::ST_RUN: begin
        if (causeSet) begin
          state_next = bsl_pkg::ST_STRAP;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= bsl_pkg::ST_STRAP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Strap latches and the policy captured alongside them
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      strapBits_reg <= bsl_pkg::STRAP_RESET;
      policy_reg    <= bsl_pkg::POLICY_ALWAYS;
    end else if (sampleNow) begin
      strapBits_reg[bsl_pkg::PRINT_BIT]    <= printStrapPin;
      strapBits_reg[bsl_pkg::BOOT_SEL_BIT] <= bootSelectStrapPin;
      policy_reg                           <= bootLogPrintPolicy;
    end
  end

  bsl_boot_decode u_decode (
    .strapBits    (strapBits_reg),
    .printPolicy  (policy_reg),
    .bootMode     (decodedMode),
    .printEnable  (decodedPrint),
    .uartDownload (decodedUart)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bootMode_reg     <= bsl_pkg::BOOT_FLASH;
      printEnable_reg  <= 1'b0;
      uartDownload_reg <= 1'b0;
    end else begin
      bootMode_reg     <= decodedMode;
      printEnable_reg  <= decodedPrint && (state_reg == bsl_pkg::ST_RUN);
      uartDownload_reg <= decodedUart && (state_reg == bsl_pkg::ST_RUN);
    end
  end

  // Chip logic held while enable is low
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      chipActive_reg <= 1'b0;
    end else begin
      chipActive_reg <= chipEnable && (state_next == bsl_pkg::ST_RUN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pullUpDis_reg <= 1'b0;
    end else if (regWrite && (regAddr == bsl_pkg::STRAP_CTRL_OFS)) begin
      pullUpDis_reg <= regWrData[bsl_pkg::CTRL_PULLUP_DIS_BIT];
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[bsl_pkg::STS_STRAP_LSB +: 2]  = strapBits_reg;
    statusWord[bsl_pkg::STS_MODE_LSB +: 2]   = bootMode_reg;
    statusWord[bsl_pkg::STS_PRINT_BIT]       = printEnable_reg;
    statusWord[bsl_pkg::STS_VALID_BIT]       = (state_reg == bsl_pkg::ST_RUN);
    statusWord[bsl_pkg::STS_UART_BIT]        = uartDownload_reg;
    statusWord[bsl_pkg::STS_POLICY_LSB +: 2] = policy_reg;
    ctrlWord = '0;
    ctrlWord[bsl_pkg::CTRL_PULLUP_DIS_BIT]   = pullUpDis_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData_reg <= '0;
    end else if (regRead && (regAddr == bsl_pkg::STRAP_STATUS_OFS)) begin
      regRdData_reg <= statusWord;
    end else if (regRead && (regAddr == bsl_pkg::STRAP_CTRL_OFS)) begin
      regRdData_reg <= ctrlWord;
    end else begin
      regRdData_reg <= '0;
    end
  end

  // Pull-up forced on while the pin serves as a strap
  assign bootSelectPullUpEn = (state_reg == bsl_pkg::ST_STRAP) || !pullUpDis_reg;
  assign strapPinsReleased  = (state_reg == bsl_pkg::ST_RUN);
  assign chipActive         = chipActive_reg;
  assign bootMode           = bootMode_reg;
  assign printEnable        = printEnable_reg;
  assign uartDownloadEn     = uartDownload_reg;
  assign regRdData          = regRdData_reg;

  chk_latch_sample: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow |=> (strapBits_reg[bsl_pkg::BOOT_SEL_BIT] == $past(bootSelectStrapPin))
      && (strapBits_reg[bsl_pkg::PRINT_BIT] == $past(printStrapPin)))
    else $error("strap latch missed sample");

  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_reg == bsl_pkg::ST_RUN) |=> $stable(strapBits_reg))
    else $error("strap bits changed after release");

  chk_pullup_strap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !strapPinsReleased |-> bootSelectPullUpEn)
    else $error("pull-up off during strapping");

  chk_status_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    regRead && (regAddr == bsl_pkg::STRAP_STATUS_OFS)
    |=> regRdData[1:0] == $past(strapBits_reg))
    else $error("status read wrong strap bits");

  chk_release_sample: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow |=> strapPinsReleased)
    else $error("pins not released after sample");

  chk_flash_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && bootSelectStrapPin |-> ##2 bootMode == bsl_pkg::BOOT_FLASH)
    else $error("flash boot not selected");

  chk_download_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && !bootSelectStrapPin && printStrapPin
    |-> ##2 bootMode == bsl_pkg::BOOT_JOINT_DOWNLOAD)
    else $error("download boot not selected");

  chk_uart_download: assert property (@(posedge clk_sys) disable iff (!reset_n)
    uartDownloadEn |-> bootMode == bsl_pkg::BOOT_JOINT_DOWNLOAD)
    else $error("uart download outside download boot");

  chk_print_never: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && (bootLogPrintPolicy == bsl_pkg::POLICY_NEVER) ##1 !causeSet
    |=> !printEnable)
    else $error("print enabled under never policy");

  chk_print_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && (bootLogPrintPolicy == bsl_pkg::POLICY_WHEN_LOW) ##1 !causeSet
    |=> printEnable == !$past(printStrapPin, 2))
    else $error("print gate wrong under low policy");

  chk_enable_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !chipEnable |=> !chipActive)
    else $error("chip active with enable low");

  chk_low_qualify: assert property (@(posedge clk_sys) disable iff (!reset_n)
    strapPinsReleased && !chipEnable && (lowCount_reg != CNT_LAST)
    && !watchdogReset && !brownoutReset |=> strapPinsReleased)
    else $error("short enable pulse reset the straps");

  chk_mode_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    strapPinsReleased && $past(strapPinsReleased) && $past(strapPinsReleased, 2)
    |-> $stable(bootMode) && $stable(printEnable))
    else $error("boot outputs moved between resets");

  cov_flash_boot: cover property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && bootSelectStrapPin ##2 bootMode == bsl_pkg::BOOT_FLASH);

  cov_download_boot: cover property (@(posedge clk_sys) disable iff (!reset_n)
    sampleNow && !bootSelectStrapPin ##2 uartDownloadEn);

  cov_watchdog_resample: cover property (@(posedge clk_sys) disable iff (!reset_n)
    strapPinsReleased && watchdogReset ##[1:8] sampleNow);

  cov_por_resample: cover property (@(posedge clk_sys) disable iff (!reset_n)
    porSet ##[1:20] sampleNow);

endmodule

`default_nettype wire

//--- bsl_strap_partner.sv
// Outside strap driver: host GPIOs on both strap pins, or the pull-up on the boot-select pin.
// Assumes the bench raises hold around each qualifying reset.
`default_nettype none
module bsl_strap_partner (
  input  wire logic clk_sys,
  input  wire logic hold,
  input  wire logic wantPrint,
  input  wire logic wantSel,
  input  wire logic selFloat,
  input  wire logic pullUpEn,
  output var  logic printPin,
  output var  logic selPin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic toggleReg = 1'h0;
  // Ordinary pin traffic once the hold time is over
  always @(posedge clk_sys) toggleReg <= ~toggleReg;
  always_comb begin
    printPin = hold ? wantPrint : toggleReg;
    if (!hold)
      selPin = ~toggleReg;
    else if (selFloat)
      selPin = pullUpEn ? 1'h1 : toggleReg;
    else
      selPin = wantSel;
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench of the strap latch beside the outside strap driver.
// Assumes the enable-low count is shortened to 8 cycles.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CE_LOW = 8;
  localparam logic [7:0] STS = bsl_pkg::STRAP_STATUS_OFS;
  localparam logic [7:0] CTRL = bsl_pkg::STRAP_CTRL_OFS;
  localparam bsl_pkg::bsl_boot_mode_type FL = bsl_pkg::BOOT_FLASH;
  localparam bsl_pkg::bsl_boot_mode_type DL = bsl_pkg::BOOT_JOINT_DOWNLOAD;
  typedef struct {
    int                         kind;
    logic                       prt, sel, flt, pe, uart;
    logic [1:0]                 pol;
    bsl_pkg::bsl_boot_mode_type mode;
  } bsl_row_type;
  logic clk_sys, reset_n, chipEnable, watchdogReset, brownoutReset;
  logic hold, wantPrint, wantSel, selFloat, printStrapPin, bootSelectStrapPin;
  logic bootSelectPullUpEn, strapPinsReleased, chipActive, printEnable;
  logic uartDownloadEn, regWrite, regRead;
  logic [1:0]  bootLogPrintPolicy;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  bsl_pkg::bsl_boot_mode_type bootMode;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Kind: 0 watchdog, 1 brownout, 2 long enable low, 3 reset; no row has both straps low
  bsl_row_type rows [9] = '{
    '{0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, FL},
    '{1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h1, FL},
    '{2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h1, FL},
    '{0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 2'h2, DL},
    '{1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 2'h2, FL},
    '{2, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h3, DL},
    '{0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0, FL},
    '{1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 2'h3, FL},
    '{3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h1, DL}};

  bsl_strap_latch #(.CE_LOW_CYCLES(CE_LOW)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .chipEnable(chipEnable),
    .watchdogReset(watchdogReset), .brownoutReset(brownoutReset),
    .printStrapPin(printStrapPin), .bootSelectStrapPin(bootSelectStrapPin),
    .bootLogPrintPolicy(bootLogPrintPolicy), .bootSelectPullUpEn(bootSelectPullUpEn),
    .strapPinsReleased(strapPinsReleased), .chipActive(chipActive), .bootMode(bootMode),
    .printEnable(printEnable), .uartDownloadEn(uartDownloadEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  bsl_strap_partner strapDrv (
    .clk_sys(clk_sys), .hold(hold), .wantPrint(wantPrint), .wantSel(wantSel),
    .selFloat(selFloat), .pullUpEn(bootSelectPullUpEn), .printPin(printStrapPin),
    .selPin(bootSelectStrapPin));

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'h0;
    @(negedge clk_sys);
    chk(name, regRdData, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'h0;
  endtask

  function automatic logic [31:0] sts(input bsl_row_type r);
    return {23'h0, r.pol, r.uart, 1'h1, r.pe, r.mode, r.sel | r.flt, r.prt};
  endfunction

  task automatic run_row(input bsl_row_type r);
    @(posedge clk_sys);
    hold <= 1'h1;
    wantPrint <= r.prt;
    wantSel <= r.sel;
    selFloat <= r.flt;
    bootLogPrintPolicy <= r.pol;
    watchdogReset <= (r.kind == 0);
    brownoutReset <= (r.kind == 1);
    chipEnable <= (r.kind != 2);
    reset_n <= (r.kind != 3);
    repeat (r.kind == 2 ? CE_LOW : (r.kind == 3 ? 2 : 1)) @(posedge clk_sys);
    reset_n <= 1'h1;
    watchdogReset <= 1'h0;
    brownoutReset <= 1'h0;
    chipEnable <= 1'h1;
    @(negedge clk_sys);
    chk("released", strapPinsReleased, 1'h0);
    if (r.kind >= 2) chk("active", chipActive, 1'h0);
    @(negedge clk_sys);
    chk("released", strapPinsReleased, 1'h1);
    @(posedge clk_sys);
    hold <= 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("mode", {30'h0, bootMode}, {30'h0, r.mode});
    chk("print", printEnable, r.pe);
    chk("uart", uartDownloadEn, r.uart);
    rdc("status", STS, sts(r));
  endtask

  initial begin
    reset_n = 1'h0;
    chipEnable = 1'h1;
    watchdogReset = 1'h0;
    brownoutReset = 1'h0;
    hold = 1'h1;
    wantPrint = 1'h1;
    wantSel = 1'h0;
    selFloat = 1'h1;
    bootLogPrintPolicy = 2'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'h0;
    regRead = 1'h0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pullup", bootSelectPullUpEn, 1'h1);
    chk("released", strapPinsReleased, 1'h0);
    chk("active", chipActive, 1'h0);
    chk("rdata", regRdData, 32'h0);
    @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (2) @(negedge clk_sys);
    chk("released", strapPinsReleased, 1'h1);
    chk("active", chipActive, 1'h1);
    @(posedge clk_sys);
    hold <= 1'h0;
    rdc("status", STS, sts(rows[6]));
    foreach (rows[i]) run_row(rows[i]);
    // Short enable dip drops activity but keeps the latched straps
    @(posedge clk_sys);
    hold <= 1'h1;
    wantPrint <= 1'h0;
    wantSel <= 1'h1;
    selFloat <= 1'h0;
    chipEnable <= 1'h0;
    repeat (CE_LOW - 1) @(posedge clk_sys);
    chipEnable <= 1'h1;
    @(negedge clk_sys);
    chk("active", chipActive, 1'h0);
    chk("released", strapPinsReleased, 1'h1);
    repeat (2) @(negedge clk_sys);
    chk("active", chipActive, 1'h1);
    rdc("status", STS, sts(rows[8]));
    @(posedge clk_sys);
    hold <= 1'h0;
    wr(CTRL, 32'h1);
    @(negedge clk_sys);
    chk("pullup", bootSelectPullUpEn, 1'h0);
    rdc("ctrl", CTRL, 32'h1);
    wr(STS, 32'hFFFFFFFF);
    rdc("status", STS, sts(rows[8]));
    rdc("unmapped", 8'h08, 32'h0);
    wr(CTRL, 32'h0);
    @(negedge clk_sys);
    chk("pullup", bootSelectPullUpEn, 1'h1);
    final_report();
  end
endmodule
`default_nettype wire
